/* File: core/slot_map_pkg.sv */
package slot_map_pkg;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [7:0] LANE3_ROUTE_OFFSET = 8'h2A;
  localparam logic [7:0] LANE4_ROUTE_OFFSET = 8'h2B;
  localparam logic [7:0] LANE5_ROUTE_OFFSET = 8'h2C;
  localparam logic [7:0] LANE3_ROUTE_RESET = 8'h02;
  localparam logic [7:0] LANE4_ROUTE_RESET = 8'h03;
  localparam logic [7:0] LANE5_ROUTE_RESET = 8'h04;
  localparam int SLOT_LSB = 0;
  localparam int SLOT_MSB = 4;
  localparam int SOURCE_LSB = 5;
  localparam int SOURCE1_MSB = 5;
  localparam int SOURCE2_MSB = 6;
  localparam logic [4:0] RIGHT_HALF_BASE = 5'h10;

  // --------------------------------------------------------------
  // lane 5 source codes
  // --------------------------------------------------------------
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_PLAYBACK = 2'h1;
  localparam logic [1:0] SRC_LOOPBACK = 2'h2;

  localparam int LANES = 3;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 16;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic [4:0] index;
    logic right;
    logic [WORD_W-1:0] data;
  } slot_word_t;

  typedef struct packed {
    logic [1:0] lane;
    logic loopback;
    logic [WORD_W-1:0] data;
  } route_entry_t;

  localparam int ENTRY_W = $bits(route_entry_t);

endpackage

/* File: core/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // word_fifo

/* File: core/secondary_serial_rx_slot_map.sv */
`timescale 1ns/1ps
module secondary_serial_rx_slot_map
  import slot_map_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  // frame format from the serial framer
  input wire logic format_tdm,
  // received slot words
  input wire logic slot_valid,
  output logic slot_ready,
  input wire slot_word_t slot_word,
  // record channel 1 word for loopback
  input wire logic [WORD_W-1:0] loopback_word,
  // routed words toward playback
  output logic route_valid,
  input wire logic route_ready,
  output route_entry_t route_entry
);

  // --------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------
  logic [1:0] source_q [LANES];
  logic [4:0] slot_q [LANES];
  logic [7:0] rdata_q;

  localparam logic [7:0] OFFSETS [LANES] = '{
    LANE3_ROUTE_OFFSET, LANE4_ROUTE_OFFSET, LANE5_ROUTE_OFFSET};
  localparam logic [7:0] RESETS [LANES] = '{
    LANE3_ROUTE_RESET, LANE4_ROUTE_RESET, LANE5_ROUTE_RESET};

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_reg
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          slot_q[g] <= RESETS[g][SLOT_MSB:SLOT_LSB];
          source_q[g] <= RESETS[g][SOURCE2_MSB:SOURCE_LSB];
        end else if (reg_wr_en && reg_addr == OFFSETS[g]) begin
          slot_q[g] <= reg_wdata[SLOT_MSB:SLOT_LSB];
          if (g == LANES - 1) begin
            source_q[g] <= reg_wdata[SOURCE2_MSB:SOURCE_LSB];
          end else begin
            // one enable bit only, upper bit held at zero
            source_q[g] <= {1'b0, reg_wdata[SOURCE1_MSB]};
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // read back
  // --------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < LANES; i++) begin
      if (reg_addr == OFFSETS[i]) begin
        // reserved bits above the source field read zero
        rd_mux = {1'b0, source_q[i], slot_q[i]};
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_en) begin
      rdata_q <= rd_mux;
    end
  end
  assign reg_rdata = rdata_q;

  // --------------------------------------------------------------
  // slot match per lane
  // --------------------------------------------------------------
  logic [LANES-1:0] hit;
  logic [LANES-1:0] enabled;
  generate
    for (g = 0; g < LANES; g++) begin : g_match
      logic tdm_hit;
      logic half_hit;
      // code 3 on lane 5 is reserved; treated as off
      assign enabled[g] = (source_q[g] == SRC_PLAYBACK) ||
                          (g == LANES - 1 && source_q[g] == SRC_LOOPBACK);
      assign tdm_hit = (slot_word.index == slot_q[g]);
      assign half_hit = slot_q[g] < RIGHT_HALF_BASE ?
        (!slot_word.right && slot_word.index == slot_q[g]) :
        (slot_word.right &&
         slot_word.index == slot_q[g] - RIGHT_HALF_BASE);
      // a disabled lane never captures the word
      assign hit[g] = enabled[g] &&
                      (format_tdm ? tdm_hit : half_hit);
    end
  endgenerate

  // --------------------------------------------------------------
  // capture and fan-out
  // --------------------------------------------------------------
  // one captured word may go to several lanes; they leave one per
  // cycle, so the source is stalled until all copies are queued
  logic [LANES-1:0] pend_q;
  logic [LANES-1:0] pend_d;
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] loop_q;
  logic loop_sel_q;
  logic ready_q;
  logic [LANES-1:0] pick;
  logic fifo_in_ready;
  logic push;
  logic take;
  route_entry_t push_entry;

  assign take = slot_valid && ready_q;
  assign pick = pend_q & (~pend_q + 1'b1);
  assign push = (pend_q != '0);

  always_comb begin
    push_entry.lane = 2'h0;
    push_entry.loopback = 1'b0;
    push_entry.data = word_q;
    for (int i = 0; i < LANES; i++) begin
      if (pick[i]) begin
        push_entry.lane = 2'(i);
        if (i == LANES - 1 && loop_sel_q) begin
          push_entry.loopback = 1'b1;
          push_entry.data = loop_q;
        end
      end
    end
  end

  always_comb begin
    pend_d = pend_q;
    if (push && fifo_in_ready) begin
      pend_d = pend_q & ~pick;
    end
    if (take) begin
      pend_d = hit;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= '0;
      ready_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      ready_q <= (pend_d == '0);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      word_q <= '0;
      loop_q <= '0;
      loop_sel_q <= 1'b0;
    end else if (take) begin
      word_q <= slot_word.data;
      loop_q <= loopback_word;
      // source sampled at take, so a later write cannot relabel copies
      loop_sel_q <= (source_q[LANES-1] == SRC_LOOPBACK);
    end
  end
  assign slot_ready = ready_q;

  // --------------------------------------------------------------
  // output register
  // --------------------------------------------------------------
  // keeps route_valid and route_entry off the memory read mux; the
  // queue moves up whenever the register is empty or being drained
  logic fifo_out_valid;
  logic fifo_out_ready;
  route_entry_t fifo_out_data;
  logic out_valid_q;
  route_entry_t out_entry_q;

  assign fifo_out_ready = !out_valid_q || route_ready;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_q <= 1'b0;
      out_entry_q <= '0;
    end else if (fifo_out_ready) begin
      out_valid_q <= fifo_out_valid;
      out_entry_q <= fifo_out_data;
    end
  end
  assign route_valid = out_valid_q;
  assign route_entry = out_entry_q;

  // --------------------------------------------------------------
  // output queue
  // --------------------------------------------------------------
  word_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_entry),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

endmodule // secondary_serial_rx_slot_map

/* File: bench/slot_map_asserts.sv */
`timescale 1ns/1ps
module slot_map_asserts
  import slot_map_pkg::*;
(
  // watched ports
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic slot_valid,
  input wire logic slot_ready,
  input wire logic route_valid,
  input wire logic route_ready,
  input wire route_entry_t route_entry
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_lane34_reserved:
  assert property (reg_rd_en && (reg_addr == LANE3_ROUTE_OFFSET ||
    reg_addr == LANE4_ROUTE_OFFSET) |=> reg_rdata[7:6] == 2'h0)
    else $error("lane 3/4 bits 7-6 set");
  a_lane5_reserved:
  assert property (reg_rd_en && reg_addr == LANE5_ROUTE_OFFSET
    |=> !reg_rdata[7])
    else $error("lane 5 bit 7 set");
  a_unmapped_zero:
  assert property (reg_rd_en && reg_addr > LANE5_ROUTE_OFFSET
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds:
  assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_ready_take:
  assert property ($fell(slot_ready) |-> $past(slot_valid && slot_ready))
    else $error("ready fell without a take");
  a_ready_back:
  assert property ($fell(slot_ready) |-> ##[1:200] slot_ready)
    else $error("ready stuck low");
  a_entry_holds:
  assert property (route_valid && !route_ready
    |=> route_valid && $stable(route_entry)) else $error("entry lost");
  a_lane_code:
  assert property (route_valid && route_entry.loopback |-> route_entry.lane
    == 2'h2) else $error("loopback on a lane other than 5");
endmodule // slot_map_asserts

/* File: bench/frame_source.sv */
`timescale 1ns/1ps
module frame_source
  import slot_map_pkg::*;
(
  // bench side, then block side
  input wire logic clock,
  input wire logic go,
  input wire slot_word_t word_in,
  input wire logic slot_ready,
  output logic slot_valid = 1'b0,
  output slot_word_t slot_word = '0
);
  // once taken the word lines stop showing the old value
  always @(posedge clock)
    if (go) begin
      slot_valid <= 1'b1;
      slot_word <= word_in;
    end else if (slot_valid && slot_ready) begin
      slot_valid <= 1'b0;
      slot_word <= ~slot_word;
    end
endmodule // frame_source

/* File: bench/secondary_serial_rx_slot_map_test.sv */
`timescale 1ns/1ps
module secondary_serial_rx_slot_map_test;
  import slot_map_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic format_tdm = 1'b1;
  logic go = 1'b0;
  logic route_ready = 1'b1;
  logic [WORD_W-1:0] loopback_word = '0;
  slot_word_t word_in = '0;
  logic [7:0] reg_rdata;
  logic slot_valid, slot_ready, route_valid;
  slot_word_t slot_word;
  route_entry_t route_entry;
  route_entry_t expq[$];
  int mismatches = 0;
  int n_checks = 0;
  always #2 clock = ~clock;
  secondary_serial_rx_slot_map dut (.clock, .reset_n, .reg_addr, .reg_wr_en,
    .reg_wdata, .reg_rd_en, .reg_rdata, .format_tdm, .slot_valid,
    .slot_ready, .slot_word, .loopback_word, .route_valid, .route_ready,
    .route_entry);
  frame_source src (.clock, .go, .word_in, .slot_ready, .slot_valid,
    .slot_word);
  task automatic check(input logic [ENTRY_W-1:0] seen, expd);
    n_checks++;
    if (seen !== expd) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clock);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    @(posedge clock);
    check(reg_rdata, e);
  endtask
  // m: lanes expected to hit; lb: lane 5 takes the loopback word
  task automatic tx(input logic [4:0] idx, input logic rt,
                    input logic [31:0] d, input logic [2:0] m,
                    input logic lb);
    int k;
    for (int i = 0; i < 3; i++)
      if (m[i]) expq.push_back({2'(i), lb && i == 2, lb && i == 2 ? ~d : d});
    @(posedge clock);
    word_in <= '{index: idx, right: rt, data: d};
    loopback_word <= ~d;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (slot_valid && k < 60);
  endtask
  // an empty queue gives x as the expected entry, so a stray entry always mismatches
  always @(posedge clock)
    if (route_valid && route_ready)
      check(route_entry, expq.size() > 0 ? expq.pop_front() : 'x);
  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(8'h2A, 8'h02);
    rd(8'h2B, 8'h03);
    rd(8'h2C, 8'h04);
    rd(8'h30, 8'h00);
    wr(8'h2A, 8'h25);
    rd(8'h2A, 8'h25);
    wr(8'h2B, 8'h25);
    wr(8'h2C, 8'h45);
    rd(8'h2C, 8'h45);
    tx(5'h05, 1'b0, 32'hA5A5_0001, 3'b111, 1'b1);
    tx(5'h06, 1'b0, 32'h0000_0002, 3'b000, 1'b0);
    wr(8'h2B, 8'h05);
    tx(5'h05, 1'b1, 32'h0000_0003, 3'b101, 1'b1);
    format_tdm <= 1'b0;
    wr(8'h2A, 8'h35);
    wr(8'h2C, 8'h25);
    tx(5'h05, 1'b1, 32'h0000_0004, 3'b001, 1'b0);
    tx(5'h05, 1'b0, 32'h0000_0005, 3'b100, 1'b0);
    // let the last copy drain before the queue is held
    repeat (3) @(posedge clock);
    route_ready <= 1'b0;
    // 16 queue words plus the output register, then one word stalls
    for (int i = 0; i < 18; i++) tx(5'h05, 1'b1, 32'(i), 3'b001, 1'b0);
    check(slot_ready, 1'b0);
    route_ready <= 1'b1;
    wr(8'h2A, 8'h15);
    wr(8'h2C, 8'h05);
    tx(5'h05, 1'b1, 32'h0000_0006, 3'b000, 1'b0);
    tx(5'h05, 1'b0, 32'h0000_0007, 3'b000, 1'b0);
    for (int k = 0; k < 80 && expq.size() > 0; k++) @(posedge clock);
    repeat (4) @(posedge clock);
    check(expq.size(), 0);
    end_of_test();
  end
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule // secondary_serial_rx_slot_map_test
bind secondary_serial_rx_slot_map slot_map_asserts chk (.clock, .reset_n,
  .reg_addr, .reg_rd_en, .reg_rdata, .slot_valid, .slot_ready,
  .route_valid, .route_ready, .route_entry);
